// ### src/lau_divider.sv
// restoring divider: one quotient bit per clock, caller guarantees hi < divisor
module lau_divider #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // request
  input  wire logic         start,
  input  wire logic [W-1:0] dvd_hi,
  input  wire logic [W-1:0] dvd_lo,
  input  wire logic [W-1:0] dvsr,
  // answer
  output logic              done,
  output logic [W-1:0]      quot,
  output logic [W-1:0]      rem
);

  localparam int CW = $clog2(W + 1);

  logic [W:0]    rem_r;    // partial remainder, one spare bit
  logic [W:0]    rem_nxt;
  logic [W-1:0]  quo_r;    // dividend low word shifting into quotient
  logic [W-1:0]  quo_nxt;
  logic [W-1:0]  dvsr_r;   // held divisor
  logic [W-1:0]  dvsr_nxt;
  logic [CW-1:0] cnt_r;    // steps left
  logic [CW-1:0] cnt_nxt;
  logic          done_r;   // one-cycle completion pulse
  logic          done_nxt;
  logic [W:0]    shifted;  // remainder after pulling in next dividend bit
  logic          qbit;     // quotient bit of this step

  // next-state for one division step
  always_comb
  begin
    rem_nxt  = rem_r;
    quo_nxt  = quo_r;
    dvsr_nxt = dvsr_r;
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    shifted  = {rem_r[W-1:0], quo_r[W-1]};
    qbit     = (shifted >= {1'b0, dvsr_r});
    if (start)
    begin
      // load; hi < divisor so remainder fits in one word
      rem_nxt  = {1'b0, dvd_hi};
      quo_nxt  = dvd_lo;
      dvsr_nxt = dvsr;
      cnt_nxt  = CW'(W);
    end
    else if (cnt_r != '0)
    begin
      // subtract when it fits, shift the quotient bit in
      rem_nxt  = qbit ? (shifted - {1'b0, dvsr_r}) : shifted;
      quo_nxt  = {quo_r[W-2:0], qbit};
      cnt_nxt  = cnt_r - CW'(1);
      done_nxt = (cnt_r == CW'(1));
    end
  end

  // step registers
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rem_r  <= '0;
      quo_r  <= '0;
      dvsr_r <= '0;
      cnt_r  <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      rem_r  <= rem_nxt;
      quo_r  <= quo_nxt;
      dvsr_r <= dvsr_nxt;
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
  assign quot = quo_r;
  assign rem  = rem_r[W-1:0];

endmodule

// ### src/lau_pkg.sv
package lau_pkg;

  // default machine word; 16 and 32 are the supported builds
  localparam int WORD_W_DEF = 32;

  // operation code width
  localparam int OP_W = 4;

  // operation codes presented with the start pulse
  localparam logic [3:0] OP_SIGNED_ADD_CARRY       = 4'h0;
  localparam logic [3:0] OP_UNSIGNED_SUM_CARRY     = 4'h1;
  localparam logic [3:0] OP_SIGNED_SUB_BORROW      = 4'h2;
  localparam logic [3:0] OP_UNSIGNED_DIFF_BORROW   = 4'h3;
  localparam logic [3:0] OP_UNSIGNED_MUL_ACC       = 4'h4;
  localparam logic [3:0] OP_UNSIGNED_DOUBLE_DIVIDE = 4'h5;
  localparam logic [3:0] OP_DOUBLE_LOGICAL_RIGHT   = 4'h6;
  localparam logic [3:0] OP_DOUBLE_LOGICAL_LEFT    = 4'h7;
  localparam logic [3:0] OP_DOUBLE_A               = 4'h8;
  localparam logic [3:0] OP_ARITH_RIGHT_SHIFT      = 4'h9;
  localparam logic [3:0] OP_ARITH_LEFT_SHIFT       = 4'hA;

  // edges from start to done for single-cycle operations
  localparam int LAT_SINGLE = 1;

  // control states of the top sequencer
  typedef enum logic [0:0]
  {
    LAU_IDLE,
    LAU_DIV_WAIT
  } lau_state_t;

endpackage

// ### src/lau_top.sv
// Operation
// - signed add with carry, overflow invalidates
// - only carry bit zero is added
// - unsigned sum returns carry and sum
// - signed subtract with borrow, overflow invalidates
// - unsigned difference returns borrow and difference
// - multiply-accumulate gives double word, upper first
// - double by single divide, quotient then remainder
// - divide overflow flagged; zero divisor invalid
// - double right shift, zero fill, count bounded
// - double left shift, zero fill, count bounded
// - double_a until top bit set, count first
// - all-zero double_a gives two to word width on norm_count, zero count in res0
// - arithmetic right shift replicates sign bit
// - arithmetic left shift flags overflow when shifting back does not restore the operand
// - word width is 16 or 32 bits
// - signed add overflow raises error flag
// - multiply carry word added in full
module lau_top #(
  parameter int WORD_W = lau_pkg::WORD_W_DEF
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_b,
  // request from the sequencer
  input  wire logic                     start,
  input  wire logic [lau_pkg::OP_W-1:0] op_code,
  input  wire logic [WORD_W-1:0]        opnd_a,
  input  wire logic [WORD_W-1:0]        opnd_b,
  input  wire logic [WORD_W-1:0]        opnd_c,
  // answer to the sequencer
  output logic                          done,
  output logic                          busy,
  output logic                          ovf_err,
  output logic [WORD_W-1:0]             res0,
  output logic [WORD_W-1:0]             res1,
  output logic [WORD_W-1:0]             res2,
  output logic [WORD_W:0]               norm_count
);

  // build word width
  // only 16 and 32 are supported builds; other widths are not guarded here
  localparam int W = WORD_W;

  lau_pkg::lau_state_t state_r;   // sequencer state
  lau_pkg::lau_state_t state_nxt;
  logic              done_r;      // answer pulse
  logic              done_nxt;
  logic              ovf_r;       // error flag to sequencer
  logic              ovf_nxt;
  logic [W-1:0]      res0_r;      // first result word
  logic [W-1:0]      res0_nxt;
  logic [W-1:0]      res1_r;      // second result word
  logic [W-1:0]      res1_nxt;
  logic [W-1:0]      res2_r;      // third result word
  logic [W-1:0]      res2_nxt;
  logic [W:0]        norm_r;      // full-width double_a count
  logic [W:0]        norm_nxt;

  // datapath terms, combinational except the registered divider outputs
  logic [W:0]        sum_w;       // add with carry-out
  logic [W:0]        diff_w;      // subtract with borrow-out
  logic [2*W-1:0]    prod_w;      // multiply-accumulate
  logic [2*W-1:0]    pair_w;      // double operand {a,b}
  logic [2*W-1:0]    shr_w;       // double logical right
  logic [2*W-1:0]    shl_w;       // double logical left
  logic [2*W-1:0]    norm_w;      // normalised pair
  logic [W:0]        lz_w;        // leading zero count of the pair
  logic [W-1:0]      ashr_w;      // arithmetic right
  logic [W-1:0]      ashl_w;      // arithmetic left
  logic              ashl_ovf;    // shifting back does not restore opnd_a
  logic              add_ovf;     // signed add overflow
  logic              sub_ovf;     // signed subtract overflow
  logic              div_bad;     // quotient too wide or divisor zero
  logic              div_go;      // launch the divider
  logic              div_done;
  logic [W-1:0]      div_quot;
  logic [W-1:0]      div_rem;

  // arithmetic terms
  always_comb
  begin
    sum_w   = {1'b0, opnd_a} + {1'b0, opnd_b} + {{W{1'b0}}, opnd_c[0]};
    diff_w  = {1'b0, opnd_a} - {1'b0, opnd_b} - {{W{1'b0}}, opnd_c[0]};
    add_ovf = (opnd_a[W-1] == opnd_b[W-1]) && (sum_w[W-1] != opnd_a[W-1]);
    sub_ovf = (opnd_a[W-1] != opnd_b[W-1]) && (diff_w[W-1] != opnd_a[W-1]);
    prod_w  = ({{W{1'b0}}, opnd_a} * {{W{1'b0}}, opnd_b}) + {{W{1'b0}}, opnd_c};
    // hi >= divisor also covers divisor zero
    div_bad = (opnd_a >= opnd_c);
  end

  // shifters and normaliser
  always_comb
  begin
    pair_w = {opnd_a, opnd_b};
    // zero filled, counts past 2W give zero
    shr_w  = pair_w >> opnd_c;
    shl_w  = pair_w << opnd_c;
    // count leading zeros; scan from lsb so the top one wins
    lz_w   = {1'b1, {W{1'b0}}};
    for (int i = 0; i < 2 * W; i++)
    begin
      if (pair_w[i])
      begin
        lz_w = (W + 1)'(2 * W - 1 - i);
      end
    end
    // zero input keeps the 2^W count and a zero pair
    norm_w = (pair_w == '0) ? '0 : (pair_w << lz_w);
    // sign replicated; counts of W or more give all sign
    ashr_w = W'($signed(opnd_a) >>> opnd_b);
    ashl_w = opnd_a << opnd_b;
    // overflow unless shifting back restores the operand
    if (opnd_b >= W)
    begin
      ashl_ovf = (opnd_a != '0);
    end
    else
    begin
      ashl_ovf = (W'($signed(ashl_w) >>> opnd_b) != opnd_a);
    end
  end

  // requests while busy are ignored
  assign div_go = start && (state_r == lau_pkg::LAU_IDLE)
                  && (op_code == lau_pkg::OP_UNSIGNED_DOUBLE_DIVIDE) && !div_bad;

  // iterative divider
  lau_divider #(
    .W (W)
  ) u_div (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .start   (div_go),
    .dvd_hi  (opnd_a),
    .dvd_lo  (opnd_b),
    .dvsr    (opnd_c),
    .done    (div_done),
    .quot    (div_quot),
    .rem     (div_rem)
  );

  // sequencer and result selection
  always_comb
  begin
    state_nxt = state_r;
    done_nxt  = 1'b0;
    ovf_nxt   = ovf_r;
    res0_nxt  = res0_r;
    res1_nxt  = res1_r;
    res2_nxt  = res2_r;
    norm_nxt  = norm_r;
    unique case (state_r)
      lau_pkg::LAU_IDLE:
      begin
        if (start)
        begin
          // results and flag posted with done
          done_nxt = 1'b1;
          ovf_nxt  = 1'b0;
          res0_nxt = '0;
          res1_nxt = '0;
          res2_nxt = '0;
          norm_nxt = '0;
          case (op_code)
            lau_pkg::OP_SIGNED_ADD_CARRY:
            begin
              res0_nxt = sum_w[W-1:0];
              ovf_nxt  = add_ovf;
            end
            lau_pkg::OP_UNSIGNED_SUM_CARRY:
            begin
              res0_nxt = {{(W-1){1'b0}}, sum_w[W]};
              res1_nxt = sum_w[W-1:0];
            end
            lau_pkg::OP_SIGNED_SUB_BORROW:
            begin
              res0_nxt = diff_w[W-1:0];
              ovf_nxt  = sub_ovf;
            end
            lau_pkg::OP_UNSIGNED_DIFF_BORROW:
            begin
              res0_nxt = {{(W-1){1'b0}}, diff_w[W]};
              res1_nxt = diff_w[W-1:0];
            end
            lau_pkg::OP_UNSIGNED_MUL_ACC:
            begin
              res0_nxt = prod_w[2*W-1:W];
              res1_nxt = prod_w[W-1:0];
            end
            lau_pkg::OP_UNSIGNED_DOUBLE_DIVIDE:
            begin
              // bad quotient answers at once with the flag
              if (div_bad)
              begin
                ovf_nxt = 1'b1;
              end
              else
              begin
                done_nxt  = 1'b0;
                state_nxt = lau_pkg::LAU_DIV_WAIT;
              end
            end
            lau_pkg::OP_DOUBLE_LOGICAL_RIGHT:
            begin
              res0_nxt = shr_w[2*W-1:W];
              res1_nxt = shr_w[W-1:0];
            end
            lau_pkg::OP_DOUBLE_LOGICAL_LEFT:
            begin
              res0_nxt = shl_w[2*W-1:W];
              res1_nxt = shl_w[W-1:0];
            end
            lau_pkg::OP_DOUBLE_A:
            begin
              // count first, then upper and lower
              res0_nxt = lz_w[W-1:0];
              res1_nxt = norm_w[2*W-1:W];
              res2_nxt = norm_w[W-1:0];
              norm_nxt = lz_w;
            end
            lau_pkg::OP_ARITH_RIGHT_SHIFT:
            begin
              res0_nxt = ashr_w;
            end
            lau_pkg::OP_ARITH_LEFT_SHIFT:
            begin
              res0_nxt = ashl_w;
              ovf_nxt  = ashl_ovf;
            end
            default:
            begin
              // unknown code answers zero with no error
              res0_nxt = '0;
            end
          endcase
        end
      end
      lau_pkg::LAU_DIV_WAIT:
      begin
        if (div_done)
        begin
          res0_nxt  = div_quot;
          res1_nxt  = div_rem;
          done_nxt  = 1'b1;
          state_nxt = lau_pkg::LAU_IDLE;
        end
      end
    endcase
  end

  // result registers; outputs come straight from these
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= lau_pkg::LAU_IDLE;
      done_r  <= 1'b0;
      ovf_r   <= 1'b0;
      res0_r  <= '0;
      res1_r  <= '0;
      res2_r  <= '0;
      norm_r  <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      done_r  <= done_nxt;
      ovf_r   <= ovf_nxt;
      res0_r  <= res0_nxt;
      res1_r  <= res1_nxt;
      res2_r  <= res2_nxt;
      norm_r  <= norm_nxt;
    end
  end

  // busy also registered, high while the divider runs
  logic busy_r;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_r <= 1'b0;
    end
    else
    begin
      busy_r <= (state_nxt == lau_pkg::LAU_DIV_WAIT);
    end
  end

  assign done       = done_r;
  assign busy       = busy_r;
  assign ovf_err    = ovf_r;
  assign res0       = res0_r;
  assign res1       = res1_r;
  assign res2       = res2_r;
  assign norm_count = norm_r;

endmodule

// ### verification/lau_seq_model.sv
// sequencer: issues one operation, then waits for its answer
module lau_seq_model #(
  parameter int W = 16
) (
  // clock
  input  wire logic                     ref_clk,
  // request to the block
  output logic                          start,
  output logic [lau_pkg::OP_W-1:0]      op_code,
  output logic [W-1:0]                  opnd_a,
  output logic [W-1:0]                  opnd_b,
  output logic [W-1:0]                  opnd_c,
  // answer
  input  wire logic                     done
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet request lines from time zero
  initial
  begin
    start   = 1'b0;
    op_code = '0;
    opnd_a  = '0;
    opnd_b  = '0;
    opnd_c  = '0;
  end
  // one-cycle strobe, launched just after an edge
  task automatic strobe(input logic [3:0] op, input logic [W-1:0] a, b, c);
    @(posedge ref_clk);
    start   <= 1'b1;
    op_code <= op;
    opnd_a  <= a;
    opnd_b  <= b;
    opnd_c  <= c;
    @(posedge ref_clk);
    start <= 1'b0;
  endtask
  // one strobe, then a bounded wait for done
  task automatic issue(input logic [3:0] op, input logic [W-1:0] a, b, c, output logic late);
    strobe(op, a, b, c);
    wait_done(late);
  endtask
  // done is looked at 1 ns after each edge, where it has settled
  task automatic wait_done(output logic late);
    int n;
    n = 0;
    #1;
    // a divide needs W+2 edges; 40 covers both builds
    while (done !== 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    late = (done !== 1'b1);
  endtask
endmodule

// ### verification/lau_top_sva.sv
// watches the sequencer side of the block; one clock domain
module lau_top_chk #(
  parameter int WORD_W = lau_pkg::WORD_W_DEF
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_b,
  // request
  input  wire logic                     start,
  input  wire logic [lau_pkg::OP_W-1:0] op_code,
  input  wire logic [WORD_W-1:0]        opnd_a,
  input  wire logic [WORD_W-1:0]        opnd_b,
  input  wire logic [WORD_W-1:0]        opnd_c,
  // answer
  input  wire logic                     done,
  input  wire logic                     busy,
  input  wire logic                     ovf_err,
  input  wire logic [WORD_W-1:0]        res0,
  input  wire logic [WORD_W-1:0]        res1,
  input  wire logic [WORD_W-1:0]        res2,
  input  wire logic [WORD_W:0]          norm_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // load, one step per bit, capture, then done
  localparam int DIV_LAT = WORD_W + 2;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // a request the block accepts
  logic go;
  assign go = start && !busy;
  // valid divide: quotient fits
  sequence s_div_go;
    go && op_code == lau_pkg::OP_UNSIGNED_DOUBLE_DIVIDE && opnd_c > opnd_a;
  endsequence
  property p_one_edge;
    go && op_code != lau_pkg::OP_UNSIGNED_DOUBLE_DIVIDE |=> done && !busy;
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("single op not answered next cycle");
  property p_sadd;
    go && op_code == lau_pkg::OP_SIGNED_ADD_CARRY |=> res0 == $past(opnd_a) + $past(opnd_b) + $past(opnd_c[0])
      && ovf_err == ($past(opnd_a[WORD_W-1]) == $past(opnd_b[WORD_W-1]) && res0[WORD_W-1] != $past(opnd_a[WORD_W-1]));
  endproperty
  a_sadd: assert property (p_sadd) else $error("signed add value or flag wrong");
  property p_usum;
    go && op_code == lau_pkg::OP_UNSIGNED_SUM_CARRY |=> !ovf_err
      && {res0, res1} == $past(opnd_a) + $past(opnd_b) + $past(opnd_c[0]);
  endproperty
  a_usum: assert property (p_usum) else $error("unsigned sum wrong");
  property p_mac;
    go && op_code == lau_pkg::OP_UNSIGNED_MUL_ACC |=> !ovf_err
      && {res0, res1} == $past(opnd_a) * $past(opnd_b) + $past(opnd_c);
  endproperty
  a_mac: assert property (p_mac) else $error("multiply accumulate wrong");
  property p_div_wait;
    s_div_go |=> (busy && !done)[*8];
  endproperty
  a_div_wait: assert property (p_div_wait) else $error("divide not busy");
  property p_div_res;
    s_div_go |-> ##DIV_LAT done && !busy && !ovf_err && res1 < $past(opnd_c, DIV_LAT)
      && res0 * $past(opnd_c, DIV_LAT) + res1 == {$past(opnd_a, DIV_LAT), $past(opnd_b, DIV_LAT)};
  endproperty
  a_div_res: assert property (p_div_res) else $error("divide result wrong");
  // quotient too large or zero divisor
  property p_div_ovf;
    go && op_code == lau_pkg::OP_UNSIGNED_DOUBLE_DIVIDE && opnd_c <= opnd_a |=> done && ovf_err;
  endproperty
  a_div_ovf: assert property (p_div_ovf) else $error("divide overflow not flagged");
  property p_dleft;
    go && op_code == lau_pkg::OP_DOUBLE_LOGICAL_LEFT && opnd_c <= 2 * WORD_W
      |=> {res0, res1} == {$past(opnd_a), $past(opnd_b)} << $past(opnd_c);
  endproperty
  a_dleft: assert property (p_dleft) else $error("double left shift wrong");
endmodule

bind lau_top lau_top_chk #(.WORD_W(WORD_W)) u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .start(start),
  .op_code(op_code), .opnd_a(opnd_a), .opnd_b(opnd_b), .opnd_c(opnd_c), .done(done), .busy(busy),
  .ovf_err(ovf_err), .res0(res0), .res1(res1), .res2(res2), .norm_count(norm_count));

// ### verification/tb_long_arithmetic_unit.sv
module tb_long_arithmetic_unit;
  timeunit 1ns;
  timeprecision 1ps;
  // narrow build keeps the divide short
  localparam int W = 16;
  // clock, reset, request, answer
  logic                     ref_clk;
  logic                     rst_b;
  logic                     start;
  logic [lau_pkg::OP_W-1:0] op_code;
  logic [W-1:0]             opnd_a;
  logic [W-1:0]             opnd_b;
  logic [W-1:0]             opnd_c;
  logic                     done;
  logic                     busy;
  logic                     ovf_err;
  logic [W-1:0]             res0;
  logic [W-1:0]             res1;
  logic [W-1:0]             res2;
  logic [W:0]               norm_count;
  int                       err_total;
  int                       n_tests;

  lau_top #(.WORD_W(W)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .start(start), .op_code(op_code),
    .opnd_a(opnd_a), .opnd_b(opnd_b), .opnd_c(opnd_c), .done(done), .busy(busy), .ovf_err(ovf_err),
    .res0(res0), .res1(res1), .res2(res2), .norm_count(norm_count));
  lau_seq_model #(.W(W)) seq (.ref_clk(ref_clk), .start(start), .op_code(op_code), .opnd_a(opnd_a),
    .opnd_b(opnd_b), .opnd_c(opnd_c), .done(done));

  // 200 MHz
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [W:0] seen, input logic [W:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // compare res0 to res2, ovf_err and busy in the cycle done stands; a timeout ends the run
  task automatic judge(input logic late, input logic [W-1:0] e0, e1, e2, input logic eo);
    if (late)
    begin
      err_total++;
      wrap_up();
    end
    check("res0", {1'b0, res0}, {1'b0, e0});
    check("res1", {1'b0, res1}, {1'b0, e1});
    check("res2", {1'b0, res2}, {1'b0, e2});
    check("ovf_err", {{W{1'b0}}, ovf_err}, {{W{1'b0}}, eo});
    check("busy", {{W{1'b0}}, busy}, {(W + 1){1'b0}});
  endtask

  // issue one operation and judge its answer
  task automatic run(input logic [3:0] op, input logic [W-1:0] a, b, c, e0, e1, e2, input logic eo);
    logic late;
    seq.issue(op, a, b, c, late);
    judge(late, e0, e1, e2, eo);
  endtask

  // a start while dividing is dropped; only the divide answers
  task automatic t_refuse();
    logic late;
    seq.strobe(lau_pkg::OP_UNSIGNED_DOUBLE_DIVIDE, 16'h1, 16'h0, 16'h3);
    seq.strobe(lau_pkg::OP_SIGNED_ADD_CARRY, 16'h1, 16'h1, 16'h0);
    seq.wait_done(late);
    judge(late, 16'h5555, 16'h1, 16'h0, 1'b0);
    @(posedge ref_clk);
    #1;
    check("done", {{W{1'b0}}, done}, {(W + 1){1'b0}});
    $display("test refuse done");
  endtask

  task automatic t_arith();
    run(lau_pkg::OP_SIGNED_ADD_CARRY, 16'h7FFF, 16'h0, 16'h1, 16'h8000, 16'h0, 16'h0, 1'b1);
    run(lau_pkg::OP_SIGNED_ADD_CARRY, 16'h5, 16'h3, 16'hFFFE, 16'h8, 16'h0, 16'h0, 1'b0);
    run(lau_pkg::OP_UNSIGNED_SUM_CARRY, 16'hFFFF, 16'h0, 16'h3, 16'h1, 16'h0, 16'h0, 1'b0);
    run(lau_pkg::OP_SIGNED_SUB_BORROW, 16'h8000, 16'h1, 16'h0, 16'h7FFF, 16'h0, 16'h0, 1'b1);
    run(lau_pkg::OP_SIGNED_SUB_BORROW, 16'h0, 16'h0, 16'h3, 16'hFFFF, 16'h0, 16'h0, 1'b0);
    run(lau_pkg::OP_UNSIGNED_DIFF_BORROW, 16'h0, 16'h0, 16'h1, 16'h1, 16'hFFFF, 16'h0, 1'b0);
    run(lau_pkg::OP_UNSIGNED_MUL_ACC, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0, 16'h0, 1'b0);
    run(4'hF, 16'h1, 16'h1, 16'h1, 16'h0, 16'h0, 16'h0, 1'b0);
    $display("test arith done");
  endtask

  task automatic t_div();
    run(lau_pkg::OP_UNSIGNED_DOUBLE_DIVIDE, 16'h1, 16'h0, 16'h3, 16'h5555, 16'h1, 16'h0, 1'b0);
    run(lau_pkg::OP_UNSIGNED_DOUBLE_DIVIDE, 16'hFFFE, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFE, 16'h0, 1'b0);
    run(lau_pkg::OP_UNSIGNED_DOUBLE_DIVIDE, 16'h3, 16'h1234, 16'h3, 16'h0, 16'h0, 16'h0, 1'b1);
    run(lau_pkg::OP_UNSIGNED_DOUBLE_DIVIDE, 16'h0, 16'h5, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1);
    $display("test div done");
  endtask

  task automatic t_shift();
    run(lau_pkg::OP_DOUBLE_LOGICAL_RIGHT, 16'h8001, 16'h8001, 16'h1, 16'h4000, 16'hC000, 16'h0, 1'b0);
    run(lau_pkg::OP_DOUBLE_LOGICAL_RIGHT, 16'h8001, 16'h8001, 16'h1F, 16'h0, 16'h1, 16'h0, 1'b0);
    run(lau_pkg::OP_DOUBLE_LOGICAL_RIGHT, 16'h8001, 16'h8001, 16'h20, 16'h0, 16'h0, 16'h0, 1'b0);
    run(lau_pkg::OP_DOUBLE_LOGICAL_LEFT, 16'h8001, 16'h8001, 16'h1, 16'h3, 16'h2, 16'h0, 1'b0);
    run(lau_pkg::OP_DOUBLE_LOGICAL_LEFT, 16'h8001, 16'h8001, 16'h10, 16'h8001, 16'h0, 16'h0, 1'b0);
    $display("test shift done");
  endtask

  task automatic t_norm();
    run(lau_pkg::OP_DOUBLE_A, 16'h0, 16'h1, 16'h0, 16'h1F, 16'h8000, 16'h0, 1'b0);
    check("norm_count", norm_count, 17'h1F);
    run(lau_pkg::OP_DOUBLE_A, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
    check("norm_count", norm_count, 17'h1_0000);
    $display("test norm done");
  endtask

  task automatic t_ashift();
    run(lau_pkg::OP_ARITH_RIGHT_SHIFT, 16'h8000, 16'hF, 16'h0, 16'hFFFF, 16'h0, 16'h0, 1'b0);
    run(lau_pkg::OP_ARITH_RIGHT_SHIFT, 16'h7FF0, 16'h10, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
    run(lau_pkg::OP_ARITH_LEFT_SHIFT, 16'h4000, 16'h1, 16'h0, 16'h8000, 16'h0, 16'h0, 1'b1);
    run(lau_pkg::OP_ARITH_LEFT_SHIFT, 16'hC000, 16'h1, 16'h0, 16'h8000, 16'h0, 16'h0, 1'b0);
    $display("test ashift done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    err_total = 0;
    n_tests   = 0;
    rst_b     = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_arith();
    t_div();
    t_shift();
    t_norm();
    t_ashift();
    t_refuse();
    wrap_up();
  end
endmodule
